// ### rtl/dma_cell_cmd_int_control.sv
// command, status and interrupt control of the four-channel dma cell
module dma_cell_cmd_int_control (
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire dma_cell_pkg::host_access_type host,            // register access
  input  wire dma_cell_pkg::dma_events_type  events,          // engine events
  input  wire logic                          serial_pending,  // serial cell has priority
  input  wire logic                          chain_enable_in, // daisy-chain input pin
  input  wire logic                          int_ack_n,       // acknowledge pin, low active
  output logic      [7:0]                    host_rdata,      // read data
  output logic      [3:0]                    chan_enable,     // channel enables to engine
  output logic                               int_request,     // interrupt request
  output logic                               chain_enable_out,// daisy-chain output
  output logic      [7:0]                    vector_data,     // vector byte
  output logic                               vector_oe        // high while vector driven
);

  ////////////////////////////////////////////////////////////////////////////////
  // host access: at pointer zero a write is a channel command that also
  // loads the pointer, and a read returns transfer status and clears it;
  // with a nonzero pointer the next access of either kind goes to that
  // register and the pointer falls back to zero
  // acknowledge: the pin passes two sync flops, so the cell acts on the
  // third edge after the pin falls and shows the vector from that same edge
  // limitation: an acknowledge shorter than the sync delay ends before the vector shows,
  // which is why the host holds the pin low for many cycles

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  dma_cell_pkg::state_type st_reg;       // all state of the cell
  dma_cell_pkg::state_type st_next;      // next state

  logic                    iei_sync;     // synchronised chain input
  logic                    ack_sync;     // synchronised acknowledge, high active

  logic [3:0]              pend_enabled; // pending and individually enabled
  logic [3:0]              req_vec;      // channels allowed to request
  logic [3:0]              pend_grant;   // highest pending and enabled
  logic                    pend_any;     // something pending and enabled
  logic [3:0]              ius_grant;    // highest under-service bit
  logic                    ius_any;      // some under-service bit is set
  logic [2:0]              status_code;  // vector status field
  logic [2:0]              cmd;          // command field of written byte
  logic [3:0]              sel;          // channel selection of written byte
  logic                    master_irq_enable;          // master enable
  logic [7:0]              vec_out;      // vector with optional status

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; both pins come from outside the clock domain
  sync_two_flop iei_sync_u (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .pin_in    (chain_enable_in),
    .level_out (iei_sync)
  );

  sync_two_flop ack_sync_u (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .pin_in    (~int_ack_n),
    .level_out (ack_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt qualification
  assign master_irq_enable          = st_reg.ctrl[dma_cell_pkg::CTL_MIE];
  // vector status only looks at pending and enabled sources
  assign pend_enabled = st_reg.ip & st_reg.ctrl[dma_cell_pkg::SEL_MSB:0] & {4{master_irq_enable}};
  // a serviced channel may not request again until cleared
  assign req_vec      = pend_enabled & ~st_reg.under_service_bit & {4{iei_sync}};
  // fields of the byte on the bus; only meaningful with a write strobe
  assign cmd          = host.wdata[dma_cell_pkg::CMD_MSB:dma_cell_pkg::CMD_LSB];
  assign sel          = host.wdata[dma_cell_pkg::SEL_MSB:0];

  // fixed priority, independent of transfer priority programming
  fixed_priority_pick #(.WIDTH(4)) pend_pick_u (
    .req   (pend_enabled),
    .grant (pend_grant),
    .any   (pend_any)
  );

  // picker for the reset-highest-service command
  fixed_priority_pick #(.WIDTH(4)) ius_pick_u (
    .req   (st_reg.under_service_bit),
    .grant (ius_grant),
    .any   (ius_any)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // vector status encoding and substitution
  always_comb begin
    // codes 001..011 are never produced
    status_code = dma_cell_pkg::VS_NONE;
    if (pend_grant[dma_cell_pkg::CH_RXA]) begin
      status_code = dma_cell_pkg::VS_RXA;
    end else if (pend_grant[dma_cell_pkg::CH_TXA]) begin
      status_code = dma_cell_pkg::VS_TXA;
    end else if (pend_grant[dma_cell_pkg::CH_RXB]) begin
      status_code = dma_cell_pkg::VS_RXB;
    end else if (pend_grant[dma_cell_pkg::CH_TXB]) begin
      status_code = dma_cell_pkg::VS_TXB;
    end
    // stored vector, bits 3..1 replaced only when status is included
    vec_out = st_reg.vector;
    if (st_reg.ctrl[dma_cell_pkg::CTL_VIS]) begin
      vec_out[dma_cell_pkg::VEC_MSB:dma_cell_pkg::VEC_LSB] = status_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    st_next = st_reg;

    ////////////////////////////////////////////////////////////////////////////
    // host writes
    if (host.wr) begin
      if (st_reg.ptr == dma_cell_pkg::ADDR_CMD_STATUS) begin
        // low five bits become the pointer for the next access
        st_next.ptr = host.wdata[dma_cell_pkg::PTR_MSB:0];
        case (cmd)
          dma_cell_pkg::CC_NULL: begin
            // null command leaves the cell as it is
          end

          dma_cell_pkg::CC_RSVD: begin
            // reserved, ignored so future codes do no harm
          end

          dma_cell_pkg::CC_CLR_HIGH: begin
            // independent of the chain input level
            if (ius_any) begin
              st_next.under_service_bit = st_reg.under_service_bit & ~ius_grant;
            end
          end

          dma_cell_pkg::CC_RESET: begin
            // channels stay off until enabled one by one
            st_next.chan_en = dma_cell_pkg::CHAN_RESET;
            st_next.tc      = dma_cell_pkg::CHAN_RESET;
            st_next.abort   = dma_cell_pkg::CHAN_RESET;
          end

          // enables only; the engine waits for its own request to start
          dma_cell_pkg::CC_EN_TXB: st_next.chan_en[dma_cell_pkg::CH_TXB] = 1'b1;
          dma_cell_pkg::CC_EN_RXB: st_next.chan_en[dma_cell_pkg::CH_RXB] = 1'b1;
          dma_cell_pkg::CC_EN_TXA: st_next.chan_en[dma_cell_pkg::CH_TXA] = 1'b1;
          dma_cell_pkg::CC_EN_RXA: st_next.chan_en[dma_cell_pkg::CH_RXA] = 1'b1;
          default: begin
            // all codes covered
          end
        endcase
      end else begin
        // second access of the pair; pointer falls back afterwards
        st_next.ptr = dma_cell_pkg::PTR_RESET;
        case (st_reg.ptr)
          dma_cell_pkg::ADDR_INT_CMD_STATUS: begin
            // bit 4 is not looked at; hosts keep it zero
            case (cmd)
              dma_cell_pkg::IC_CLR_IP:   st_next.ip  = st_reg.ip & ~sel;
              dma_cell_pkg::IC_CLR_IUS:  st_next.under_service_bit = st_reg.under_service_bit & ~sel;
              dma_cell_pkg::IC_CLR_BOTH: begin
                st_next.ip  = st_reg.ip & ~sel;
                st_next.under_service_bit = st_reg.under_service_bit & ~sel;
              end

              dma_cell_pkg::IC_SET_IP:   st_next.ip  = st_reg.ip | sel;
              dma_cell_pkg::IC_SET_IUS:  st_next.under_service_bit = st_reg.under_service_bit | sel;
              dma_cell_pkg::IC_SET_BOTH: begin
                st_next.ip  = st_reg.ip | sel;
                st_next.under_service_bit = st_reg.under_service_bit | sel;
              end

              default: begin
                // null and reserved codes change nothing
              end
            endcase
          end
          // control and vector are plain read/write bytes
          dma_cell_pkg::ADDR_INT_CONTROL: st_next.ctrl   = host.wdata;
          dma_cell_pkg::ADDR_INT_VECTOR:  st_next.vector = host.wdata;
          default: begin
            // unmapped pointer: write dropped
          end
        endcase
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host reads; data is registered, valid the cycle after the strobe
    if (host.rd) begin
      if (st_reg.ptr == dma_cell_pkg::ADDR_CMD_STATUS) begin
        st_next.rdata = {st_reg.tc, st_reg.abort};
        // read clears; an event in the same cycle is added back below
        st_next.tc    = dma_cell_pkg::CHAN_RESET;
        st_next.abort = dma_cell_pkg::CHAN_RESET;
      end else begin
        st_next.ptr = dma_cell_pkg::PTR_RESET;
        case (st_reg.ptr)
          dma_cell_pkg::ADDR_INT_CMD_STATUS: st_next.rdata = {st_reg.under_service_bit, st_reg.ip};
          dma_cell_pkg::ADDR_INT_CONTROL:    st_next.rdata = st_reg.ctrl;
          dma_cell_pkg::ADDR_INT_VECTOR:     st_next.rdata = st_reg.vector;
          // unmapped pointers read as zero
          default:                           st_next.rdata = dma_cell_pkg::BYTE_RESET;
        endcase
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // engine events set flags; set wins over any clear in the same cycle
    // so a status read in the same cycle as a count event never loses it
    st_next.tc    = st_next.tc | events.term_count;
    st_next.abort = st_next.abort | events.aborted;
    st_next.ip    = st_next.ip | events.irq_event;

    ////////////////////////////////////////////////////////////////////////////
    // acknowledge sequence
    case (st_reg.ack)
      dma_cell_pkg::ACK_IDLE: begin
        if (ack_sync) begin
          // serial cell outranks the dma cell inside the device
          if (iei_sync && pend_any && !serial_pending) begin
            st_next.under_service_bit      = st_next.under_service_bit | pend_grant;
            // the byte only shows while it is driven, so a suppressed
            // vector reads as zero at the pins
            if (st_reg.ctrl[dma_cell_pkg::CTL_NV]) begin
              st_next.vec_data = dma_cell_pkg::BYTE_RESET;
            end else begin
              st_next.vec_data = vec_out;
            end
            // no-vector option leaves the bus undriven
            st_next.vec_oe   = ~st_reg.ctrl[dma_cell_pkg::CTL_NV];
            st_next.ack      = dma_cell_pkg::ACK_OURS;
          end else begin
            st_next.ack = dma_cell_pkg::ACK_OTHER;
          end
        end
      end
      dma_cell_pkg::ACK_OURS: begin
        // hold the vector until the acknowledge ends
        if (!ack_sync) begin
          st_next.vec_oe   = 1'b0;
          st_next.vec_data = dma_cell_pkg::BYTE_RESET;
          st_next.ack      = dma_cell_pkg::ACK_IDLE;
        end
      end
      dma_cell_pkg::ACK_OTHER: begin
        // another device answers; wait for the end
        if (!ack_sync) begin
          st_next.ack = dma_cell_pkg::ACK_IDLE;
        end
      end
      default: begin
        // unused encoding: back to idle with the bus released
        st_next.ack    = dma_cell_pkg::ACK_IDLE;
        st_next.vec_oe = 1'b0;
      end
    endcase

    ////////////////////////////////////////////////////////////////////////////
    // request and chain outputs, registered to keep outputs glitch-free
    st_next.irq_req   = |req_vec;
    // any serviced channel blocks the lower chain, as does the disable bit
    st_next.chain_out = iei_sync & ~(|st_reg.under_service_bit)
                        & ~st_reg.ctrl[dma_cell_pkg::CTL_DLC];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register with synchronous reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // register bus state
      st_reg.ptr       <= dma_cell_pkg::PTR_RESET;
      st_reg.tc        <= dma_cell_pkg::CHAN_RESET;
      st_reg.abort     <= dma_cell_pkg::CHAN_RESET;
      st_reg.chan_en   <= dma_cell_pkg::CHAN_RESET;

      // interrupt programming and flags
      st_reg.ctrl      <= dma_cell_pkg::BYTE_RESET;
      st_reg.vector    <= dma_cell_pkg::BYTE_RESET;
      st_reg.ip        <= dma_cell_pkg::CHAN_RESET;
      st_reg.under_service_bit       <= dma_cell_pkg::CHAN_RESET;

      // acknowledge and output flops
      st_reg.ack       <= dma_cell_pkg::ACK_IDLE;
      st_reg.rdata     <= dma_cell_pkg::BYTE_RESET;
      st_reg.vec_data  <= dma_cell_pkg::BYTE_RESET;
      st_reg.vec_oe    <= 1'b0;
      st_reg.irq_req   <= 1'b0;
      st_reg.chain_out <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flops
  assign host_rdata       = st_reg.rdata;
  assign chan_enable      = st_reg.chan_en;
  assign int_request      = st_reg.irq_req;
  assign chain_enable_out = st_reg.chain_out;
  // vector_data reads zero whenever vector_oe is low
  assign vector_data      = st_reg.vec_data;
  assign vector_oe        = st_reg.vec_oe;

endmodule // dma_cell_cmd_int_control

// ### common/dma_cell_pkg.sv
// Overview of operation
// - command bits 7..5: 000 null, 001 reserved
// - 010 clears highest set under-service bit only
// - 011 resets cell; channels stay disabled
// - 100/101/110/111 enable txb/rxb/txa/rxa, no start
// - bits 4..0 written form register pointer
// - pointer returns to command after next access
// - status bits 7..4 flag terminal count
// - status bits 3..0 flag aborted operations
// - reading status clears count and abort flags
// - master enable clear blocks every interrupt
// - lower chain disable holds chain output low
// - no-vector bit stops vector bus drive
// - status include replaces vector bits 3..1
// - status codes 000,100 rxa,101 rxb,110 txa,111 txb
// - control bits 3..0 are per-channel enables
// - stored vector returned on acknowledge
// - interrupt commands 001/010/011 clear pending/service
// - interrupt commands 101/110/111 set pending/service
// - bits 3..0 select channels, not stored
// - fixed priority rxa, txa, rxb, txb
// - request needs pending, enables, chain in, no service
// - acknowledge sets winner's under-service bit
package dma_cell_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // pointer addresses of the cell registers
  localparam logic [4:0] ADDR_CMD_STATUS     = 5'h00; // command write, transfer status read
  localparam logic [4:0] ADDR_INT_CMD_STATUS = 5'h01; // interrupt command / interrupt status
  localparam logic [4:0] ADDR_INT_CONTROL    = 5'h02; // interrupt control
  localparam logic [4:0] ADDR_INT_VECTOR     = 5'h03; // interrupt vector

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CMD_MSB = 7;  // command field top bit
  localparam int CMD_LSB = 5;  // command field bottom bit
  localparam int PTR_MSB = 4;  // pointer field top bit
  localparam int SEL_MSB = 3;  // channel selection top bit
  localparam int CTL_MIE = 7;  // master_irq_enable
  localparam int CTL_DLC = 6;  // lower_chain_disable
  localparam int CTL_NV  = 5;  // no vector
  localparam int CTL_VIS = 4;  // vector includes status
  localparam int VEC_MSB = 3;  // vector_status_msb
  localparam int VEC_LSB = 1;  // lowest substituted vector bit

  // channel bit index, higher index is higher interrupt priority
  localparam int CH_RXA = 3;
  localparam int CH_TXA = 2;
  localparam int CH_RXB = 1;
  localparam int CH_TXB = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // channel command codes
  localparam logic [2:0] CC_NULL      = 3'h0;
  localparam logic [2:0] CC_RSVD      = 3'h1;
  localparam logic [2:0] CC_CLR_HIGH  = 3'h2;
  localparam logic [2:0] CC_RESET     = 3'h3;
  localparam logic [2:0] CC_EN_TXB    = 3'h4;
  localparam logic [2:0] CC_EN_RXB    = 3'h5;
  localparam logic [2:0] CC_EN_TXA    = 3'h6;
  localparam logic [2:0] CC_EN_RXA    = 3'h7;

  // interrupt command codes
  localparam logic [2:0] IC_NULL      = 3'h0;
  localparam logic [2:0] IC_CLR_IP    = 3'h1;
  localparam logic [2:0] IC_CLR_IUS   = 3'h2;
  localparam logic [2:0] IC_CLR_BOTH  = 3'h3;
  localparam logic [2:0] IC_RSVD      = 3'h4;
  localparam logic [2:0] IC_SET_IP    = 3'h5;
  localparam logic [2:0] IC_SET_IUS   = 3'h6;
  localparam logic [2:0] IC_SET_BOTH  = 3'h7;

  // vector status codes
  localparam logic [2:0] VS_NONE      = 3'h0;
  localparam logic [2:0] VS_RXA       = 3'h4;
  localparam logic [2:0] VS_RXB       = 3'h5;
  localparam logic [2:0] VS_TXA       = 3'h6;
  localparam logic [2:0] VS_TXB       = 3'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [4:0] PTR_RESET    = 5'h00;
  localparam logic [3:0] CHAN_RESET   = 4'h0;
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic       SYNC_RESET   = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {ACK_IDLE, ACK_OURS, ACK_OTHER} ack_state_type;

  // one-cycle events from the transfer engine
  typedef struct packed {
    logic [3:0] term_count;  // terminal count reached
    logic [3:0] aborted;     // operation aborted
    logic [3:0] irq_event;   // interrupt condition per channel
  } dma_events_type;

  // one host access, from the bus interface on ref_clk
  typedef struct packed {
    logic       wr;          // write strobe, one cycle
    logic       rd;          // read strobe, one cycle
    logic [7:0] wdata;       // write byte
  } host_access_type;

  // complete state of the cell
  typedef struct packed {
    logic [4:0]    ptr;
    logic [3:0]    tc;
    logic [3:0]    abort;
    logic [3:0]    chan_en;
    logic [7:0]    ctrl;
    logic [7:0]    vector;
    logic [3:0]    ip;
    logic [3:0]    under_service_bit;
    ack_state_type ack;
    logic [7:0]    rdata;
    logic [7:0]    vec_data;
    logic          vec_oe;
    logic          irq_req;
    logic          chain_out;
  } state_type;

endpackage

// ### rtl/sync_two_flop.sv
// two-flop synchroniser for one pin level
module sync_two_flop (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output logic      level_out
);

  logic stage_one_reg; // metastable stage, read only by the second flop

  ////////////////////////////////////////////////////////////////////////////////
  // both stages clear with the synchronous reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stage_one_reg <= dma_cell_pkg::SYNC_RESET;
      level_out     <= dma_cell_pkg::SYNC_RESET;
    end else begin
      stage_one_reg <= pin_in;
      level_out     <= stage_one_reg;
    end
  end

endmodule // sync_two_flop

// ### rtl/fixed_priority_pick.sv
// picks the highest set bit; highest index wins
module fixed_priority_pick #(
  parameter int WIDTH = 4
) (
  input  wire logic [WIDTH-1:0] req,
  output logic      [WIDTH-1:0] grant,
  output logic                  any
);

  logic found; // a higher bit already won

  ////////////////////////////////////////////////////////////////////////////////
  // scan from the top so the highest priority request is granted
  always_comb begin
    found = 1'b0;
    grant = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (req[i] && !found) begin
        grant[i] = 1'b1;
        found    = 1'b1;
      end
    end
    any = found;
  end

endmodule // fixed_priority_pick

// ### test/host_ack_model.sv
// host side of the acknowledge: one low pulse on the pin per request
module host_ack_model #(
  parameter int ACK_LEN = 12  // cycles the pin stays low
) (
  input  wire logic ref_clk,
  input  wire logic ack_req,
  output logic      int_ack_n
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;  // remaining low cycles
  initial int_ack_n = 1'b1;
  // request sampled on the edge, pin moved just after it; no new cycle
  // until the pin is back high, so acknowledges never overlap
  always @(posedge ref_clk) begin
    if (cnt != 0) cnt = cnt - 1;
    else if (ack_req) cnt = ACK_LEN;
    #1 int_ack_n = (cnt == 0);
  end
endmodule // host_ack_model

// ### test/dma_cell_cmd_int_control_checker.sv
// port-level properties of the command and interrupt block
module dma_cell_cmd_int_control_checker (
  input wire logic                          ref_clk,
  input wire logic                          sys_rst,
  input wire dma_cell_pkg::host_access_type host,
  input wire dma_cell_pkg::dma_events_type  events,
  input wire logic                          serial_pending,
  input wire logic                          chain_enable_in,
  input wire logic                          int_ack_n,
  input wire logic [7:0]                    host_rdata,
  input wire logic [3:0]                    chan_enable,
  input wire logic                          int_request,
  input wire logic                          chain_enable_out,
  input wire logic [7:0]                    vector_data,
  input wire logic                          vector_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////
  // four low cycles cover the two sync flops and the output register
  property p_chain_low; !chain_enable_in [*4] |=> !chain_enable_out; endproperty
  a_chain_low: assert property (p_chain_low) else $error("chain out high");
  property p_req_low; !chain_enable_in [*4] |=> !int_request; endproperty
  a_req_low: assert property (p_req_low) else $error("request w/o chain");
  property p_oe_ack; $rose(vector_oe) |-> !$past(int_ack_n, 2); endproperty
  a_oe_ack: assert property (p_oe_ack) else $error("vector w/o ack");
  property p_oe_zero; !vector_oe |-> vector_data == 8'h00; endproperty
  a_oe_zero: assert property (p_oe_zero) else $error("vector idle");
  property p_rd_hold; !$past(host.rd) |-> $stable(host_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
  property p_en_hold; !$past(host.wr) |-> $stable(chan_enable); endproperty
  a_en_hold: assert property (p_en_hold) else $error("enable moved");
  property p_oe_chain; $rose(vector_oe) |=> !chain_enable_out; endproperty
  a_oe_chain: assert property (p_oe_chain) else $error("chain stays up");
  property p_oe_ser; $rose(vector_oe) |-> !$past(serial_pending); endproperty
  a_oe_ser: assert property (p_oe_ser) else $error("serial ignored");
endmodule // dma_cell_cmd_int_control_checker

bind dma_cell_cmd_int_control dma_cell_cmd_int_control_checker u_checker (
  .ref_clk, .sys_rst, .host, .events, .serial_pending, .chain_enable_in,
  .int_ack_n, .host_rdata, .chan_enable, .int_request, .chain_enable_out,
  .vector_data, .vector_oe);

// ### test/tb_top.sv
// register-level bench for the command and interrupt block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                          ref_clk         = 1'b0;
  logic                          sys_rst         = 1'b1;
  dma_cell_pkg::host_access_type host            = '0;
  dma_cell_pkg::dma_events_type  events          = '0;
  logic                          serial_pending  = 1'b0;
  logic                          chain_enable_in = 1'b1;
  logic                          ack_req         = 1'b0;
  logic                          int_ack_n;
  logic [7:0]                    host_rdata;
  logic [3:0]                    chan_enable;
  logic                          int_request;
  logic                          chain_enable_out;
  logic [7:0]                    vector_data;
  logic                          vector_oe;
  int                            error_cnt       = 0;
  int                            check_count     = 0;
  // interrupt command byte, then expected {service, pending}
  logic [15:0] icmd [8] = '{16'hae0f, 16'hc33f, 16'h421f, 16'h2c13,
                            16'h6f00, 16'he555, 16'h8f55, 16'h0f55};
  always #2 ref_clk = ~ref_clk;
  dma_cell_cmd_int_control u_dma_cell_cmd_int_control (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .host(host), .events(events),
    .serial_pending(serial_pending), .chain_enable_in(chain_enable_in),
    .int_ack_n(int_ack_n), .host_rdata(host_rdata), .chan_enable(chan_enable),
    .int_request(int_request), .chain_enable_out(chain_enable_out),
    .vector_data(vector_data), .vector_oe(vector_oe));
  host_ack_model u_host_ack_model (.ref_clk(ref_clk), .ack_req(ack_req),
    .int_ack_n(int_ack_n));
  //////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one write strobe plus an idle cycle, so strobes never merge
  task automatic put(input logic [7:0] d);
    host.wr = 1'b1;
    host.wdata = d;
    @(posedge ref_clk) #1 host.wr = 1'b0;
    @(posedge ref_clk) #1;
  endtask
  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    put({3'h0, a});
    put(d);
  endtask
  task automatic rreg(input logic [4:0] a, input logic [7:0] exp);
    if (a != 5'h00) put({3'h0, a});
    host.rd = 1'b1;
    @(posedge ref_clk) #1 host.rd = 1'b0;
    @(posedge ref_clk) #1 chk(host_rdata, exp);
  endtask
  // acknowledge cycle; the vector is looked at while the pin is low
  task automatic ack(input logic oe, input logic [7:0] v);
    ack_req = 1'b1;
    @(posedge ref_clk) #1 ack_req = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 chk({7'h00, vector_oe}, {7'h00, oe});
    chk(vector_data, v);
    repeat (14) @(posedge ref_clk);
    #1;
  endtask
  task automatic conclude;
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    conclude();
  end
  initial begin
    logic [3:0] exp_en;
    exp_en = 4'h0;
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    @(posedge ref_clk) #1;
    rreg(5'h02, 8'h00);
    rreg(5'h03, 8'h00);
    chk({4'h0, chan_enable}, 8'h00);
    for (int k = 4; k < 8; k++) begin
      put({k[2:0], 5'h00});
      exp_en[k-4] = 1'b1;
      chk({4'h0, chan_enable}, {4'h0, exp_en});
    end
    put(8'h20);
    put(8'h00);
    chk({4'h0, chan_enable}, 8'h0f);
    put(8'h60);
    chk({4'h0, chan_enable}, 8'h00);
    // engine events in a single cycle
    events.term_count = 4'ha;
    events.aborted = 4'h5;
    events.irq_event = 4'h1;
    @(posedge ref_clk) #1 events = '0;
    rreg(5'h00, 8'ha5);
    rreg(5'h00, 8'h00);
    rreg(5'h01, 8'h01);
    foreach (icmd[i]) begin
      wreg(5'h01, icmd[i][15:8]);
      rreg(5'h01, icmd[i][7:0]);
    end
    // clear highest service bit with the chain input low
    chain_enable_in = 1'b0;
    put(8'h40);
    rreg(5'h01, 8'h15);
    chain_enable_in = 1'b1;
    wreg(5'h01, 8'h6f);
    wreg(5'h01, 8'ha1);
    wreg(5'h02, 8'h01);
    rreg(5'h00, 8'h00);
    chk({7'h00, int_request}, 8'h00);
    wreg(5'h02, 8'h81);
    chk({7'h00, int_request}, 8'h01);
    chk({7'h00, chain_enable_out}, 8'h01);
    wreg(5'h02, 8'hc1);
    chk({7'h00, chain_enable_out}, 8'h00);
    wreg(5'h02, 8'h81);
    chain_enable_in = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 chk({7'h00, int_request}, 8'h00);
    chk({7'h00, chain_enable_out}, 8'h00);
    chain_enable_in = 1'b1;
    // vectors: receive B outranks transmit B
    wreg(5'h03, 8'hae);
    wreg(5'h01, 8'ha2);
    wreg(5'h02, 8'h93);
    ack(1'b1, 8'haa);
    rreg(5'h01, 8'h23);
    wreg(5'h01, 8'h42);
    wreg(5'h02, 8'h83);
    ack(1'b1, 8'hae);
    wreg(5'h01, 8'h42);
    wreg(5'h02, 8'ha3);
    ack(1'b0, 8'h00);
    wreg(5'h01, 8'h42);
    wreg(5'h02, 8'h93);
    serial_pending = 1'b1;
    ack(1'b0, 8'h00);
    serial_pending = 1'b0;
    wreg(5'h01, 8'ha8);
    wreg(5'h02, 8'h9b);
    ack(1'b1, 8'ha8);
    conclude();
  end
endmodule // tb_top
